// File: hw/pin_mux_cfg.svh
// Offsets, field positions and reset values of the port A pin controller
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define FUNC_SEL_OFFSET 8'h80
`define DIRECTION_OFFSET 8'h82
`define FUNC_SEL_RESET 16'h0000
`define DIRECTION_RESET 16'h0000
`define FUNC_SEL_WMASK 16'h3fff
`define DIRECTION_WMASK 16'h3ff7
`define PIN_COUNT 14
`define POS_SERIAL_RX_CLOCK 13
`define POS_SERIAL_RX_SYNC 12
`define POS_SERIAL_RX_DATA 11
`define POS_SERIAL_TX_CLOCK 10
`define POS_SERIAL_TX_SYNC 9
`define POS_SERIAL_TX_DATA 8
`define POS_WATCHDOG 7
`define POS_TIMER_CLOCK 6
`define POS_TIMER_CAPTURE 5
`define POS_TIMER_COMPARE_A 4
`define POS_CLOCK_OUT 3
`define POS_LINK_STATUS 2
`define POS_NET_OUT 1
`define POS_ADDR_MATCH 0
`endif

// File: hw/pin_mux_pkg.sv
// Types shared by the port A pin controller files
package pin_mux_pkg;
    typedef logic [15:0] reg16_t;
    typedef logic [13:0] pins_t;
endpackage : pin_mux_pkg

// File: hw/pin_sync.sv
// Three-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync (
    input wire logic clock,
    input wire logic reset,
    input wire logic [13:0] d,
    output logic [13:0] q
);
    logic [13:0] s1_r;
    logic [13:0] s2_r;
    logic [13:0] s3_r;
    // Change accepted only when stages two and three agree
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_r <= 14'h0000;
            s2_r <= 14'h0000;
            s3_r <= 14'h0000;
            q <= 14'h0000;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= (s2_r & s3_r) | (q & (s2_r | s3_r));
        end
    end
endmodule : pin_sync

// File: hw/port_a_pin_function_direction.sv
// Port A pin function and direction control
// Behaviour
// - 16-bit function register, bits 13..0
// - Function register clears on power-on only
// - Bits 15,14 read zero
// - Pin13 peripheral: serial receive clock
// - Pin12 peripheral: serial receive sync
// - Pin11 peripheral: serial receive data
// - Pin10 peripheral: serial transmit clock
// - Pin9 peripheral: bidirectional transmit sync
// - Pin8 peripheral: serial transmit data out
// - Pin7 inverted: zero drives watchdog overflow
// - Pin6 peripheral: timer clock input
// - Pin5 peripheral: timer capture input
// - Pin4 peripheral: timer compare A out
// - Pin3: clock out or compare B
// - Pin2 peripheral: network link status in
// - Pin1 peripheral: network general output
// - Pin0 peripheral: address-match sense input
// - Direction register bits 13..4, 2..0
// - Direction acts only in general mode
// - Direction clears on power-on only
`timescale 1ns/1ps
module port_a_pin_function_direction (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic [13:0] pin_in,
    output logic [13:0] pin_out,
    output logic [13:0] pin_oe_n,
    input wire logic [13:0] gpio_out,
    output logic [13:0] gpio_in,
    input wire logic serial_tx_sync_out,
    input wire logic serial_tx_sync_drive,
    input wire logic serial_tx_data_out,
    input wire logic watchdog_overflow_out,
    input wire logic free_timer_compare_out_a,
    input wire logic free_timer_compare_out_b,
    input wire logic peripheral_clock_out,
    input wire logic net_general_out,
    output logic serial_rx_clock_in,
    output logic serial_rx_sync_in,
    output logic serial_rx_data_in,
    output logic serial_tx_clock_in,
    output logic serial_tx_sync_in,
    output logic free_timer_clock_in,
    output logic free_timer_capture_in,
    output logic net_link_status_in,
    output logic net_address_match_sense_in,
    output logic [15:0] func_sel_out,
    output logic [15:0] direction_out
);
    `include "pin_mux_cfg.svh"

    // ******************************
    // Register decode
    // ******************************
    // One decoder for both strobes, so a read and a write never disagree on a hit
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        addr_hit = (addr == offset);
    endfunction : addr_hit

    // Selected pin level, else the idle low a quiet peripheral expects
    function automatic logic gate_in(
        input logic selected,
        input logic level
    );
        gate_in = selected & level;
    endfunction : gate_in

    logic func_sel_hit;
    logic direction_hit;
    logic func_sel_write;
    logic direction_write;

    always_comb begin
        func_sel_hit = addr_hit(reg_addr, `FUNC_SEL_OFFSET);
        direction_hit = addr_hit(reg_addr, `DIRECTION_OFFSET);
        func_sel_write = reg_write & func_sel_hit;
        direction_write = reg_write & direction_hit;
    end

    // ******************************
    // Registers
    // ******************************
    pin_mux_pkg::reg16_t port_a_function_select_r;
    pin_mux_pkg::reg16_t port_a_function_select_nxt;
    pin_mux_pkg::reg16_t port_a_direction_r;
    pin_mux_pkg::reg16_t port_a_direction_nxt;
    pin_mux_pkg::reg16_t read_value;

    // Reserved bits never store, so they cannot leak into the decode
    always_comb begin
        port_a_function_select_nxt = port_a_function_select_r;
        if (func_sel_write) begin
            port_a_function_select_nxt = reg_wdata & `FUNC_SEL_WMASK;
        end
    end

    always_comb begin
        port_a_direction_nxt = port_a_direction_r;
        if (direction_write) begin
            port_a_direction_nxt = reg_wdata & `DIRECTION_WMASK;
        end
    end

    // Reset here is power-on only; manual reset and low-power states never reach it
    always_ff @(posedge clock) begin
        if (reset) begin
            port_a_function_select_r <= `FUNC_SEL_RESET;
        end else begin
            port_a_function_select_r <= port_a_function_select_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            port_a_direction_r <= `DIRECTION_RESET;
        end else begin
            port_a_direction_r <= port_a_direction_nxt;
        end
    end

    // ******************************
    // Register read
    // ******************************
    // Unmapped addresses read zero
    always_comb begin
        read_value = 16'h0000;
        if (func_sel_hit) begin
            read_value = port_a_function_select_r;
        end else if (direction_hit) begin
            read_value = port_a_direction_r;
        end
    end

    // Data stand one cycle only, so a stale value never looks like a second read
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= read_value;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ******************************
    // Function decode
    // ******************************
    pin_mux_pkg::pins_t periph_sel;
    pin_mux_pkg::pins_t gpio_mode;

    // Pin 7 is inverted and pin 3 has no general mode
    always_comb begin
        periph_sel = port_a_function_select_r[13:0];
        periph_sel[`POS_WATCHDOG] = ~port_a_function_select_r[`POS_WATCHDOG];
        periph_sel[`POS_CLOCK_OUT] = 1'b1;
        gpio_mode = ~periph_sel;
    end

    // ******************************
    // Peripheral outputs
    // ******************************
    pin_mux_pkg::pins_t periph_out;
    pin_mux_pkg::pins_t periph_drive;

    // Input-only functions leave the pin undriven
    always_comb begin
        periph_out = 14'h0000;
        periph_drive = 14'h0000;
        periph_out[`POS_SERIAL_TX_SYNC] = serial_tx_sync_out;
        periph_drive[`POS_SERIAL_TX_SYNC] = serial_tx_sync_drive;
        periph_out[`POS_SERIAL_TX_DATA] = serial_tx_data_out;
        periph_drive[`POS_SERIAL_TX_DATA] = 1'b1;
        periph_out[`POS_WATCHDOG] = watchdog_overflow_out;
        periph_drive[`POS_WATCHDOG] = 1'b1;
        periph_out[`POS_TIMER_COMPARE_A] = free_timer_compare_out_a;
        periph_drive[`POS_TIMER_COMPARE_A] = 1'b1;
        if (port_a_function_select_r[`POS_CLOCK_OUT]) begin
            periph_out[`POS_CLOCK_OUT] = free_timer_compare_out_b;
        end else begin
            periph_out[`POS_CLOCK_OUT] = peripheral_clock_out;
        end
        periph_drive[`POS_CLOCK_OUT] = 1'b1;
        periph_out[`POS_NET_OUT] = net_general_out;
        periph_drive[`POS_NET_OUT] = 1'b1;
    end

    // ******************************
    // Pin drive
    // ******************************
    genvar i;
    generate
        for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
            always_ff @(posedge clock) begin
                if (reset) begin
                    pin_out[i] <= 1'b0;
                end else if (periph_sel[i]) begin
                    pin_out[i] <= periph_out[i];
                end else begin
                    pin_out[i] <= gpio_out[i];
                end
            end

            // Watchdog and clock out drive from reset, so those pins start enabled
            always_ff @(posedge clock) begin
                if (reset) begin
                    pin_oe_n[i] <= (i == `POS_WATCHDOG || i == `POS_CLOCK_OUT) ? 1'b0 : 1'b1;
                end else if (periph_sel[i]) begin
                    pin_oe_n[i] <= ~periph_drive[i];
                end else begin
                    pin_oe_n[i] <= ~port_a_direction_r[i];
                end
            end
        end
    endgenerate

    // ******************************
    // Input routing
    // ******************************
    pin_mux_pkg::pins_t pin_sync_q;

    // Pins come from outside the clock domain, so each passes the synchroniser
    pin_sync u_sync (
        .clock(clock),
        .reset(reset),
        .d(pin_in),
        .q(pin_sync_q)
    );

    // Inputs idle low when not selected
    always_ff @(posedge clock) begin
        if (reset) begin
            serial_rx_clock_in <= 1'b0;
        end else begin
            serial_rx_clock_in <= gate_in(periph_sel[`POS_SERIAL_RX_CLOCK], pin_sync_q[`POS_SERIAL_RX_CLOCK]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            serial_rx_sync_in <= 1'b0;
        end else begin
            serial_rx_sync_in <= gate_in(periph_sel[`POS_SERIAL_RX_SYNC], pin_sync_q[`POS_SERIAL_RX_SYNC]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            serial_rx_data_in <= 1'b0;
        end else begin
            serial_rx_data_in <= gate_in(periph_sel[`POS_SERIAL_RX_DATA], pin_sync_q[`POS_SERIAL_RX_DATA]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            serial_tx_clock_in <= 1'b0;
        end else begin
            serial_tx_clock_in <= gate_in(periph_sel[`POS_SERIAL_TX_CLOCK], pin_sync_q[`POS_SERIAL_TX_CLOCK]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            serial_tx_sync_in <= 1'b0;
        end else begin
            serial_tx_sync_in <= gate_in(periph_sel[`POS_SERIAL_TX_SYNC], pin_sync_q[`POS_SERIAL_TX_SYNC]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            free_timer_clock_in <= 1'b0;
        end else begin
            free_timer_clock_in <= gate_in(periph_sel[`POS_TIMER_CLOCK], pin_sync_q[`POS_TIMER_CLOCK]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            free_timer_capture_in <= 1'b0;
        end else begin
            free_timer_capture_in <= gate_in(periph_sel[`POS_TIMER_CAPTURE], pin_sync_q[`POS_TIMER_CAPTURE]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            net_link_status_in <= 1'b0;
        end else begin
            net_link_status_in <= gate_in(periph_sel[`POS_LINK_STATUS], pin_sync_q[`POS_LINK_STATUS]);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            net_address_match_sense_in <= 1'b0;
        end else begin
            net_address_match_sense_in <= gate_in(periph_sel[`POS_ADDR_MATCH], pin_sync_q[`POS_ADDR_MATCH]);
        end
    end

    // ******************************
    // General port
    // ******************************
    // General port sees only pins in general mode
    always_ff @(posedge clock) begin
        if (reset) begin
            gpio_in <= 14'h0000;
        end else begin
            gpio_in <= pin_sync_q & gpio_mode;
        end
    end

    // ******************************
    // Register copies
    // ******************************
    // Copies for the port logic, one cycle behind the registers
    always_ff @(posedge clock) begin
        if (reset) begin
            func_sel_out <= 16'h0000;
        end else begin
            func_sel_out <= port_a_function_select_r;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            direction_out <= 16'h0000;
        end else begin
            direction_out <= port_a_direction_r;
        end
    end
endmodule : port_a_pin_function_direction

// File: verification/pin_mux_monitor.sv
// Port checks of the port A pin controller
`timescale 1ns/1ps
module pin_mux_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [13:0] pin_oe_n,
    input wire logic [15:0] func_sel_out,
    input wire logic [15:0] direction_out
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_rd_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
    property p_fs_rsvd; func_sel_out[15:14] == 2'b00; endproperty
    property p_dir_rsvd; {direction_out[15:14], direction_out[3]} == 3'b000; endproperty
    property p_watchdog; !func_sel_out[7] |-> !pin_oe_n[7]; endproperty
    property p_pin3; pin_oe_n[3] == 1'b0; endproperty
    property p_gp_dir; !func_sel_out[1] |-> pin_oe_n[1] == !direction_out[1]; endproperty
    property p_tx_data; func_sel_out[8] |-> !pin_oe_n[8]; endproperty
    property p_rx_only; func_sel_out[13] |-> pin_oe_n[13]; endproperty
    property p_in_only; (func_sel_out[13:0] & 14'h3c65 & ~pin_oe_n) == 14'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_fs_rsvd: assert property (p_fs_rsvd) else $error("function reserved set");
    a_dir_rsvd: assert property (p_dir_rsvd) else $error("direction reserved set");
    a_watchdog: assert property (p_watchdog) else $error("pin 7 not driven");
    a_pin3: assert property (p_pin3) else $error("pin 3 not driven");
    a_gp_dir: assert property (p_gp_dir) else $error("pin 1 direction wrong");
    a_tx_data: assert property (p_tx_data) else $error("pin 8 not driven");
    a_rx_only: assert property (p_rx_only) else $error("pin 13 driven");
    a_in_only: assert property (p_in_only) else $error("input-only pin driven");
    c_read: cover property (reg_read ##1 reg_rdata != 16'h0000);
    c_gp7: cover property (func_sel_out[7]);
    c_rx13: cover property (func_sel_out[13]);
endmodule : pin_mux_monitor
bind port_a_pin_function_direction pin_mux_monitor u_mon (.clock(clock), .reset(reset), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pin_oe_n(pin_oe_n), .func_sel_out(func_sel_out), .direction_out(direction_out));

// File: verification/peripheral_model.sv
// Peripheral outputs that face port A
`timescale 1ns/1ps
module peripheral_model (
    input wire logic [7:0] level,
    output logic [7:0] outs
);
    // Levels pass straight through; clock out and compare B get opposite values so a wrong route shows
    assign outs = level;
endmodule : peripheral_model

// File: verification/testbench.sv
// Register and pin routing tests of the port A pin controller
`timescale 1ns/1ps
module testbench;
    // ****************
    // Stimulus
    // ****************
    logic clock, reset, reg_write, reg_read;
    logic [7:0] reg_addr, level;
    logic [15:0] reg_wdata;
    wire logic [15:0] reg_rdata, fso, dro;
    logic [13:0] pin_in, gpio_out;
    wire logic [13:0] pin_out, pin_oe_n, gpio_in;
    wire logic [7:0] po;
    wire logic [8:0] pi;
    int miscompares = 0;
    int total_checks = 0;
    peripheral_model u_per (.level(level), .outs(po));
    port_a_pin_function_direction DUT (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_in(gpio_in), .serial_tx_sync_out(po[0]),
        .serial_tx_sync_drive(po[1]), .serial_tx_data_out(po[2]), .watchdog_overflow_out(po[3]),
        .free_timer_compare_out_a(po[4]), .free_timer_compare_out_b(po[5]), .peripheral_clock_out(po[6]),
        .net_general_out(po[7]), .serial_rx_clock_in(pi[8]), .serial_rx_sync_in(pi[7]),
        .serial_rx_data_in(pi[6]), .serial_tx_clock_in(pi[5]), .serial_tx_sync_in(pi[4]),
        .free_timer_clock_in(pi[3]), .free_timer_capture_in(pi[2]), .net_link_status_in(pi[1]),
        .net_address_match_sense_in(pi[0]), .func_sel_out(fso), .direction_out(dro));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask : rdc
    task wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Bounded run; a hang counts as a mismatch
    initial begin
        #50000 miscompares++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        level = 8'hd6;
        pin_in = 14'h2ac5;
        gpio_out = 14'h15aa;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rdc(8'h80, 16'h0000, "func reset");
        rdc(8'h82, 16'h0000, "dir reset");
        check("oe reset", 16'(pin_oe_n), 16'h3f77);
        check("out reset", 16'(pin_out & 14'h0088), 16'h0008);
        wr(8'h80, 16'h3fff);
        rdc(8'h80, 16'h3fff, "func rw");
        wr(8'h82, 16'hffff);
        rdc(8'h82, 16'h3ff7, "dir rw");
        rdc(8'h84, 16'h0000, "unmapped");
        repeat (8) @(posedge clock);
        check("oe periph", 16'(pin_oe_n), 16'h3c65);
        check("out periph", 16'(pin_out & 14'h039a), 16'h0192);
        check("periph in", 16'(pi), 16'h015b);
        check("gpio in", 16'(gpio_in), 16'h0080);
        check("func copy", fso, 16'h3fff);
        check("dir copy", dro, 16'h3ff7);
        level <= 8'h29;
        repeat (2) @(posedge clock);
        check("oe drive off", 16'(pin_oe_n), 16'h3e65);
        check("out swapped", 16'(pin_out & 14'h039a), 16'h0288);
        level <= 8'hd6;
        wr(8'h80, 16'h0080);
        wr(8'h82, 16'h0002);
        repeat (8) @(posedge clock);
        check("oe general", 16'(pin_oe_n), 16'h3ff5);
        check("out general", 16'(pin_out), 16'h15aa);
        check("gpio all", 16'(gpio_in), 16'h2ac5);
        check("periph off", 16'(pi), 16'h0000);
        check("func copy 2", fso, 16'h0080);
        check("dir copy 2", dro, 16'h0002);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rdc(8'h80, 16'h0000, "func again");
        rdc(8'h82, 16'h0000, "dir again");
        check("oe again", 16'(pin_oe_n), 16'h3f77);
        wrap_up();
    end
endmodule : testbench
